// ---- clock_ctrl_defines.svh ----
// Register offsets, field positions, reset values and wait counts of the clock controller.
// Assumes it is included by bare name from the package and the controller module.
`ifndef CLOCK_CTRL_DEFINES_SVH
`define CLOCK_CTRL_DEFINES_SVH

// ============================================================
// Register byte addresses
`define ADDR_SLOW_OSC_MODE 16'hff58
`define ADDR_PERIPH_DIV 16'hfff3
`define ADDR_STOP_WAIT_SEL 16'hfff4
`define ADDR_CPU_DIV 16'hfffb

// ============================================================
// Field positions inside the byte
`define BIT_CPU_DIV 3'h1
`define BIT_PERIPH_HIGH 3'h1
`define BIT_PERIPH_LOW 3'h0
`define BIT_SLOW_HALT 3'h0
`define BIT_WAIT_HIGH 3'h1
`define BIT_WAIT_LOW 3'h0

// ============================================================
// Reset values
`define RST_CPU_DIV 8'h02
`define RST_PERIPH_DIV 8'h02
`define RST_SLOW_OSC_MODE 8'h00
`define RST_STOP_WAIT_SEL 8'h00

// ============================================================
// Stabilisation waits in system-clock periods
`define WAIT_CODE0_CYCLES 1024
`define WAIT_CODE1_CYCLES 4096
`define WAIT_CODE2_CYCLES 32768
`define WAIT_CODE3_CYCLES 131072
`define WAIT_CNT_W 18

`endif

// ---- clock_ctrl_pkg.sv ----
// Types shared by the clock controller: clock source, sequencer state, bus request, state record.
// Assumes clock_ctrl_defines.svh is on the include path.
`include "clock_ctrl_defines.svh"

package clock_ctrl_pkg;

    // ============================================================
    // System clock source fixed by the nonvolatile option setting.
    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'h0,
        SRC_CRYSTAL = 2'h1,
        SRC_EXTERNAL = 2'h2
    } clk_src_t;

    // ============================================================
    // Oscillator sequencer states.
    typedef enum logic [2:0] {
        ST_BOOT = 3'h0,
        ST_RUN = 3'h1,
        ST_STOP = 3'h2,
        ST_START = 3'h3,
        ST_WAIT = 3'h4
    } osc_state_t;

    // ============================================================
    // One CPU memory access; bitWr marks a single-bit manipulation.
    typedef struct packed {
        logic [15:0] addr;
        logic wrEn;
        logic bitWr;
        logic [2:0] bitSel;
        logic [7:0] wrData;
        logic rdEn;
    } bus_req_t;

    // ============================================================
    // Complete state of the controller.
    typedef struct packed {
        osc_state_t mode;
        clk_src_t srcSel;
        logic slowStoppable;
        logic cpuDiv;
        logic [1:0] perDiv;
        logic slowHalt;
        logic [1:0] waitSel;
        logic [1:0] waitCode;
        logic [`WAIT_CNT_W-1:0] waitCnt;
        logic [3:0] prescale;
        logic cpuClkEn;
        logic periphClkEn;
        logic cpuClkRun;
        logic mainOscRun;
        logic extClkPass;
        logic slowOscRun;
        logic watchdogSlowLock;
        logic oscInPortMode;
        logic oscOutPortMode;
        logic [7:0] rdData;
    } ctrl_state_t;

endpackage : clock_ctrl_pkg

// ---- system_clock_divider_control.sv ----
// Clock-generator control: source selection, CPU and peripheral dividers, slow oscillator
// mode and the post-STOP stabilisation wait, with the four control registers.
// Assumes core_clk is the system clock and all inputs are synchronous to it.
// Functional notes
// - reset loads both dividers with 02H.
// - CPU clock ratio from three divider bits.
// - peripheral divider 01H gives half system clock.
// - peripheral divider 02H gives quarter system clock.
// - dividers accept single-bit and byte writes.
// - non-stoppable option ignores slow mode writes.
// - non-stoppable option locks watchdog to slow oscillator.
// - reset clears slow oscillator mode register.
// - slow halt bit stops slow oscillator.
// - wait codes select 2^10/12/15/17 periods.
// - wait only with crystal, after STOP or reset.
// - wait select takes byte writes only.
// - wait counting starts once oscillation started.
// - source and boot wait from option setting.
// - internal oscillator frees both oscillator pins.
// - STOP halts oscillator or blocks external clock.
`include "clock_ctrl_defines.svh"

module system_clock_divider_control #(
    parameter int unsigned WAIT_CODE0 = `WAIT_CODE0_CYCLES,
    parameter int unsigned WAIT_CODE1 = `WAIT_CODE1_CYCLES,
    parameter int unsigned WAIT_CODE2 = `WAIT_CODE2_CYCLES,
    parameter int unsigned WAIT_CODE3 = `WAIT_CODE3_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire clock_ctrl_pkg::bus_req_t busReq,
    output logic [7:0] rdData,
    input wire clock_ctrl_pkg::clk_src_t optClkSrc,
    input wire logic optSlowStoppable,
    input wire logic [1:0] optResetWait,
    input wire logic stopReq,
    input wire logic stopRelease,
    input wire logic oscStarted,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic cpuClkRun,
    output logic mainOscRun,
    output logic extClkPass,
    output logic slowOscRun,
    output logic watchdogSlowLock,
    output logic oscInPortMode,
    output logic oscOutPortMode
);

    // ============================================================
    // Helpers

    // Wait length minus one, so the counter spends exactly the full count in ST_WAIT.
    function automatic logic [`WAIT_CNT_W-1:0] waitLoad(input logic [1:0] code);
        logic [`WAIT_CNT_W-1:0] n;
        n = '0;
        case (code)
            2'h0: n = `WAIT_CNT_W'(WAIT_CODE0 - 1);
            2'h1: n = `WAIT_CNT_W'(WAIT_CODE1 - 1);
            2'h2: n = `WAIT_CNT_W'(WAIT_CODE2 - 1);
            default: n = `WAIT_CNT_W'(WAIT_CODE3 - 1);
        endcase
        return n;
    endfunction : waitLoad

    // Prescaler mask for the CPU enable; ratio is mask plus one.
    function automatic logic [3:0] cpuMask(input logic [1:0] per, input logic cpu);
        logic [3:0] m;
        m = 4'h0;
        case ({per, cpu})
            3'b000: m = 4'h0;
            3'b010: m = 4'h1;
            3'b001: m = 4'h3;
            3'b100: m = 4'h3;
            3'b011: m = 4'h7;
            3'b101: m = 4'hf;
            default: m = 4'h0; // Prohibited codes simply run undivided.
        endcase
        return m;
    endfunction : cpuMask

    // Prescaler mask for the peripheral enable.
    function automatic logic [3:0] perMask(input logic [1:0] per);
        logic [3:0] m;
        m = 4'h0;
        if (per[0]) begin
            m = 4'h1;
        end else if (per[1]) begin
            m = 4'h3;
        end
        return m;
    endfunction : perMask

    // Merges a byte or single-bit write into the old register byte.
    function automatic logic [7:0] mergeByte(input logic [7:0] old, input clock_ctrl_pkg::bus_req_t r);
        logic [7:0] b;
        b = r.wrData;
        if (r.bitWr) begin
            b = old;
            b[r.bitSel] = r.wrData[0];
        end
        return b;
    endfunction : mergeByte

    // ============================================================
    // State

    clock_ctrl_pkg::ctrl_state_t st_reg;
    clock_ctrl_pkg::ctrl_state_t st_next;
    logic [7:0] cpuByte;
    logic [7:0] perByte;
    logic [7:0] slowByte;
    logic [7:0] waitByte;

    // Readback images; reserved bits read as zero.
    always_comb begin
        cpuByte = 8'h00;
        cpuByte[`BIT_CPU_DIV] = st_reg.cpuDiv;
        perByte = 8'h00;
        perByte[`BIT_PERIPH_HIGH] = st_reg.perDiv[1];
        perByte[`BIT_PERIPH_LOW] = st_reg.perDiv[0];
        slowByte = 8'h00;
        slowByte[`BIT_SLOW_HALT] = st_reg.slowHalt;
        waitByte = 8'h00;
        waitByte[`BIT_WAIT_HIGH] = st_reg.waitSel[1];
        waitByte[`BIT_WAIT_LOW] = st_reg.waitSel[0];
    end

    // ============================================================
    // Next-state logic: register writes, sequencer, prescaler and output images.
    always_comb begin
        logic [7:0] m;
        m = 8'h00;
        st_next = st_reg;

        // Register writes; the divider pair takes bit or byte writes.
        if (busReq.wrEn) begin
            if (busReq.addr == `ADDR_CPU_DIV) begin
                m = mergeByte(cpuByte, busReq);
                st_next.cpuDiv = m[`BIT_CPU_DIV];
            end else if (busReq.addr == `ADDR_PERIPH_DIV) begin
                m = mergeByte(perByte, busReq);
                st_next.perDiv = {m[`BIT_PERIPH_HIGH], m[`BIT_PERIPH_LOW]};
            end else if (busReq.addr == `ADDR_SLOW_OSC_MODE) begin
                // Locked option makes the mode register inert.
                if (st_reg.slowStoppable) begin
                    m = mergeByte(slowByte, busReq);
                    st_next.slowHalt = m[`BIT_SLOW_HALT];
                end
            end else if (busReq.addr == `ADDR_STOP_WAIT_SEL) begin
                if (!busReq.bitWr) begin
                    st_next.waitSel = {busReq.wrData[`BIT_WAIT_HIGH], busReq.wrData[`BIT_WAIT_LOW]};
                end
            end
        end

        // Registered read port; unmapped addresses return zero.
        if (busReq.rdEn) begin
            if (busReq.addr == `ADDR_CPU_DIV) begin
                st_next.rdData = cpuByte;
            end else if (busReq.addr == `ADDR_PERIPH_DIV) begin
                st_next.rdData = perByte;
            end else if (busReq.addr == `ADDR_SLOW_OSC_MODE) begin
                st_next.rdData = slowByte;
            end else if (busReq.addr == `ADDR_STOP_WAIT_SEL) begin
                st_next.rdData = waitByte;
            end else begin
                st_next.rdData = 8'h00;
            end
        end

        // Oscillator sequencer.
        case (st_reg.mode)
            clock_ctrl_pkg::ST_BOOT: begin
                // Straps are caught one edge after reset release, never under reset.
                st_next.srcSel = optClkSrc;
                st_next.slowStoppable = optSlowStoppable;
                if (optClkSrc == clock_ctrl_pkg::SRC_CRYSTAL) begin
                    st_next.waitCode = optResetWait;
                    st_next.mode = clock_ctrl_pkg::ST_START;
                end else begin
                    st_next.mode = clock_ctrl_pkg::ST_RUN;
                end
            end
            clock_ctrl_pkg::ST_RUN: begin
                if (stopReq) begin
                    st_next.mode = clock_ctrl_pkg::ST_STOP;
                end
            end
            clock_ctrl_pkg::ST_STOP: begin
                if (stopRelease) begin
                    if (st_reg.srcSel == clock_ctrl_pkg::SRC_CRYSTAL) begin
                        st_next.waitCode = st_reg.waitSel;
                        st_next.mode = clock_ctrl_pkg::ST_START;
                    end else begin
                        st_next.mode = clock_ctrl_pkg::ST_RUN;
                    end
                end
            end
            clock_ctrl_pkg::ST_START: begin
                // The start-up interval is not part of the wait.
                if (oscStarted) begin
                    st_next.waitCnt = waitLoad(st_reg.waitCode);
                    st_next.mode = clock_ctrl_pkg::ST_WAIT;
                end
            end
            clock_ctrl_pkg::ST_WAIT: begin
                if (st_reg.waitCnt == '0) begin
                    st_next.mode = clock_ctrl_pkg::ST_RUN;
                end else begin
                    st_next.waitCnt = st_reg.waitCnt - 1'b1;
                end
            end
            default: begin
                st_next.mode = clock_ctrl_pkg::ST_BOOT;
            end
        endcase

        // Prescaler runs only while the CPU clock runs, so ratios restart cleanly.
        st_next.cpuClkEn = 1'b0;
        st_next.periphClkEn = 1'b0;
        st_next.prescale = 4'h0;
        if (st_next.mode == clock_ctrl_pkg::ST_RUN) begin
            st_next.prescale = st_reg.prescale + 4'h1;
            st_next.cpuClkEn = (st_reg.prescale & cpuMask(st_next.perDiv, st_next.cpuDiv))
                               == cpuMask(st_next.perDiv, st_next.cpuDiv);
            st_next.periphClkEn = (st_reg.prescale & perMask(st_next.perDiv))
                                  == perMask(st_next.perDiv);
        end

        // Output images, taken from the next state so the ports come from flops.
        st_next.cpuClkRun = st_next.mode == clock_ctrl_pkg::ST_RUN;
        st_next.mainOscRun = st_next.srcSel != clock_ctrl_pkg::SRC_EXTERNAL
                             && st_next.mode != clock_ctrl_pkg::ST_STOP;
        st_next.extClkPass = st_next.srcSel == clock_ctrl_pkg::SRC_EXTERNAL
                             && st_next.mode == clock_ctrl_pkg::ST_RUN;
        st_next.slowOscRun = !(st_next.slowStoppable && st_next.slowHalt);
        st_next.watchdogSlowLock = !st_next.slowStoppable;
        st_next.oscInPortMode = st_next.srcSel == clock_ctrl_pkg::SRC_INTERNAL;
        st_next.oscOutPortMode = st_next.srcSel != clock_ctrl_pkg::SRC_CRYSTAL;
    end

    // ============================================================
    // State register; the wait select has no documented reset but is cleared for determinism.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.mode <= clock_ctrl_pkg::ST_BOOT;
            st_reg.srcSel <= clock_ctrl_pkg::SRC_INTERNAL;
            st_reg.cpuDiv <= 1'(`RST_CPU_DIV >> `BIT_CPU_DIV);
            st_reg.perDiv <= 2'(`RST_PERIPH_DIV);
            st_reg.slowHalt <= 1'(`RST_SLOW_OSC_MODE >> `BIT_SLOW_HALT);
            st_reg.waitSel <= 2'(`RST_STOP_WAIT_SEL);
            st_reg.slowOscRun <= 1'b1;
            st_reg.watchdogSlowLock <= 1'b1;
            st_reg.mainOscRun <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // Ports straight from the state flops.
    assign rdData = st_reg.rdData;
    assign cpuClkEn = st_reg.cpuClkEn;
    assign periphClkEn = st_reg.periphClkEn;
    assign cpuClkRun = st_reg.cpuClkRun;
    assign mainOscRun = st_reg.mainOscRun;
    assign extClkPass = st_reg.extClkPass;
    assign slowOscRun = st_reg.slowOscRun;
    assign watchdogSlowLock = st_reg.watchdogSlowLock;
    assign oscInPortMode = st_reg.oscInPortMode;
    assign oscOutPortMode = st_reg.oscOutPortMode;

    // ============================================================
    // Checks. Helper counts the CPU enable period while the divider setting holds still.
    logic [4:0] gapCnt;
    logic gapDirty;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gapCnt <= 5'h0;
            gapDirty <= 1'b1;
        end else begin
            gapCnt <= cpuClkEn ? 5'h1 : gapCnt + 5'h1;
            if (cpuClkEn) begin
                gapDirty <= 1'b0;
            end
            if (st_reg.mode != clock_ctrl_pkg::ST_RUN || st_next.cpuDiv != st_reg.cpuDiv
                || st_next.perDiv != st_reg.perDiv) begin
                gapDirty <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    reset_values_a: assert property (st_reg.mode == clock_ctrl_pkg::ST_BOOT |->
        st_reg.cpuDiv && st_reg.perDiv == 2'h2 && !st_reg.slowHalt)
        else $error("Divider or slow mode reset value wrong.");

    cpu_ratio_a: assert property (cpuClkEn && !gapDirty && !$past(gapDirty) |->
        gapCnt == 5'(cpuMask(st_reg.perDiv, st_reg.cpuDiv)) + 5'h1)
        else $error("CPU clock enable period does not match divider.");

    // The setting must hold up to the cycle that shows the next pulse, or a write may shift it.
    periph_half_a: assert property (periphClkEn && st_reg.perDiv == 2'h1 ##1
        (st_reg.perDiv == 2'h1 && st_reg.mode == clock_ctrl_pkg::ST_RUN)[*2]
        |-> periphClkEn && !$past(periphClkEn))
        else $error("Peripheral clock is not half rate.");

    periph_quarter_a: assert property (periphClkEn && st_reg.perDiv == 2'h2 ##1
        (st_reg.perDiv == 2'h2 && st_reg.mode == clock_ctrl_pkg::ST_RUN)[*4]
        |-> periphClkEn && !$past(periphClkEn) && !$past(periphClkEn, 2)
        && !$past(periphClkEn, 3))
        else $error("Peripheral clock is not quarter rate.");

    bit_write_a: assert property (busReq.wrEn && busReq.bitWr && busReq.addr == `ADDR_CPU_DIV
        && busReq.bitSel == `BIT_CPU_DIV |=> st_reg.cpuDiv == $past(busReq.wrData[0]))
        else $error("Single-bit write to CPU divider lost.");

    slow_lock_a: assert property (st_reg.mode != clock_ctrl_pkg::ST_BOOT &&
        !st_reg.slowStoppable |-> slowOscRun && watchdogSlowLock && $stable(st_reg.slowHalt))
        else $error("Locked slow oscillator was stopped or changed.");

    slow_halt_a: assert property (busReq.wrEn && !busReq.bitWr && st_reg.slowStoppable
        && busReq.addr == `ADDR_SLOW_OSC_MODE && busReq.wrData[0] |=> ##1 !slowOscRun)
        else $error("Slow oscillator did not stop.");

    wait_load_a: assert property ($rose(st_reg.mode == clock_ctrl_pkg::ST_WAIT) |->
        st_reg.waitCnt == waitLoad(st_reg.waitCode))
        else $error("Stabilisation wait loaded with wrong length.");

    no_wait_a: assert property (st_reg.mode == clock_ctrl_pkg::ST_STOP && stopRelease &&
        st_reg.srcSel != clock_ctrl_pkg::SRC_CRYSTAL |=> st_reg.mode == clock_ctrl_pkg::ST_RUN)
        else $error("Wait inserted without crystal source.");

    wait_byte_a: assert property (busReq.wrEn && busReq.bitWr &&
        busReq.addr == `ADDR_STOP_WAIT_SEL |=> $stable(st_reg.waitSel))
        else $error("Bit write changed wait select.");

    start_hold_a: assert property (st_reg.mode == clock_ctrl_pkg::ST_START && !oscStarted
        |=> st_reg.mode == clock_ctrl_pkg::ST_START && !cpuClkRun)
        else $error("Wait began before oscillation started.");

    boot_option_a: assert property (st_reg.mode == clock_ctrl_pkg::ST_BOOT &&
        optClkSrc == clock_ctrl_pkg::SRC_CRYSTAL |=> st_reg.mode == clock_ctrl_pkg::ST_START
        && st_reg.waitCode == $past(optResetWait))
        else $error("Boot wait not taken from option setting.");

    pins_free_a: assert property (st_reg.mode != clock_ctrl_pkg::ST_BOOT &&
        st_reg.srcSel == clock_ctrl_pkg::SRC_INTERNAL |-> oscInPortMode && oscOutPortMode)
        else $error("Oscillator pins not freed.");

    stop_halt_a: assert property (st_reg.mode == clock_ctrl_pkg::ST_STOP |->
        !mainOscRun && !extClkPass && !cpuClkRun)
        else $error("Clock still runs in STOP.");

    cover_crystal_stop: cover property (st_reg.mode == clock_ctrl_pkg::ST_WAIT
        && st_reg.srcSel == clock_ctrl_pkg::SRC_CRYSTAL ##1 st_reg.mode == clock_ctrl_pkg::ST_RUN);
    cover_slow_stop: cover property (st_reg.slowStoppable && !slowOscRun);
    cover_div16: cover property (cpuClkEn && st_reg.perDiv == 2'h2 && st_reg.cpuDiv);

endmodule : system_clock_divider_control

// ---- system_clock_divider_control_tb.sv ----
// Self-checking bench for the clock controller: registers, dividers, slow oscillator, STOP waits.
// Assumes the package and its defines header are compiled first; waits are shortened.
module system_clock_divider_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Signals
    // Short waits keep every STOP sequence a few cycles long.
    localparam int W[4] = '{4, 6, 8, 10};
    logic core_clk;
    logic sys_rst;
    clock_ctrl_pkg::bus_req_t busReq;
    clock_ctrl_pkg::clk_src_t optClkSrc;
    logic optSlowStoppable, stopReq, stopRelease, oscStarted;
    logic [1:0] optResetWait;
    logic [7:0] rdData, v;
    logic cpuClkEn, periphClkEn, cpuClkRun, mainOscRun, extClkPass, slowOscRun;
    logic watchdogSlowLock, oscInPortMode, oscOutPortMode;
    logic [2:0] code [6] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h3, 3'h5};
    int cpuRatio [6] = '{1, 2, 4, 4, 8, 16};
    int perRatio [6] = '{1, 2, 1, 4, 2, 4};
    int mismatches, n_checks, cycles, n;

    system_clock_divider_control #(.WAIT_CODE0(W[0]), .WAIT_CODE1(W[1]), .WAIT_CODE2(W[2]),
        .WAIT_CODE3(W[3])) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .busReq(busReq),
        .rdData(rdData), .optClkSrc(optClkSrc), .optSlowStoppable(optSlowStoppable),
        .optResetWait(optResetWait), .stopReq(stopReq), .stopRelease(stopRelease),
        .oscStarted(oscStarted), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
        .cpuClkRun(cpuClkRun), .mainOscRun(mainOscRun), .extClkPass(extClkPass),
        .slowOscRun(slowOscRun), .watchdogSlowLock(watchdogSlowLock),
        .oscInPortMode(oscInPortMode), .oscOutPortMode(oscOutPortMode));

    // ============================================================
    // Clock and hang guard
    // The clock toggles every 25 ns, a period of 50 ns.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // A hung wait loop is cut short well past the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    // ============================================================
    // Tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [15:0] a, input logic [7:0] d, input logic bw, input logic [2:0] sel);
        @(negedge core_clk);
        busReq = '{addr: a, wrEn: 1'b1, bitWr: bw, bitSel: sel, wrData: d, rdEn: 1'b0};
        @(negedge core_clk);
        busReq.wrEn = 1'b0;
    endtask : wr

    task rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge core_clk);
        busReq.addr = a;
        busReq.rdEn = 1'b1;
        @(negedge core_clk);
        busReq.rdEn = 1'b0;
        d = rdData;
    endtask : rd

    // Pulses one sequencer input for a cycle, then counts cycles until the CPU clock runs.
    task pulse(input int which, input int lim, output int cnt);
        @(negedge core_clk);
        case (which)
            0: stopReq = 1'b1;
            1: stopRelease = 1'b1;
            default: oscStarted = 1'b1;
        endcase
        @(negedge core_clk);
        {stopReq, stopRelease, oscStarted} = 3'h0;
        cnt = 0;
        while (cpuClkRun !== 1'b1 && cnt < lim) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask : pulse

    // The first pulse found may follow a divider change, so only the second gap is kept.
    task spacing(input logic per, output int cnt);
        repeat (2) begin
            cnt = 0;
            do begin
                @(negedge core_clk);
                cnt++;
            end while ((per ? periphClkEn : cpuClkEn) !== 1'b1 && cnt < 64);
        end
    endtask : spacing

    task doReset(input clock_ctrl_pkg::clk_src_t src, input logic stp, input logic [1:0] rw);
        @(negedge core_clk);
        optClkSrc = src;
        {optSlowStoppable, optResetWait, sys_rst} = {stp, rw, 1'b1};
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        if (src == clock_ctrl_pkg::SRC_CRYSTAL) begin
            repeat (2) @(negedge core_clk);
            pulse(2, 300, n);
            check(n, W[rw]);
        end
    endtask : doReset

    task results();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // ============================================================
    // Test sequence
    initial begin
        {sys_rst, optSlowStoppable, optResetWait, stopReq, stopRelease, oscStarted} = 7'h40;
        optClkSrc = clock_ctrl_pkg::SRC_INTERNAL;
        busReq = '0;
        doReset(clock_ctrl_pkg::SRC_INTERNAL, 1'b1, 2'h0);
        rd(16'hfffb, v);
        check(v, 8'h02);
        rd(16'hfff3, v);
        check(v, 8'h02);
        rd(16'hff58, v);
        check(v, 8'h00);
        check(slowOscRun, 1'b1);
        check(watchdogSlowLock, 1'b0);
        check({oscInPortMode, oscOutPortMode}, 2'h3);
        rd(16'h1234, v);
        check(v, 8'h00);
        $display("test reset values done");
        // Each defined code: byte write for the peripheral bits, bit write for the CPU bit.
        for (int i = 0; i < 6; i++) begin
            wr(16'hfff3, {6'h0, code[i][2:1]}, 1'b0, 3'h0);
            wr(16'hfffb, {7'h0, code[i][0]}, 1'b1, 3'h1);
            rd(16'hfffb, v);
            check(v, {6'h0, code[i][0], 1'b0});
            spacing(1'b0, n);
            check(n, cpuRatio[i]);
            spacing(1'b1, n);
            check(n, perRatio[i]);
        end
        $display("test dividers done");
        pulse(0, 0, n);
        check(cpuClkRun, 1'b0);
        check(mainOscRun, 1'b0);
        pulse(1, 300, n);
        check(n, 0);
        $display("test internal stop done");
        wr(16'hff58, 8'hff, 1'b0, 3'h0);
        rd(16'hff58, v);
        check(v, 8'h01);
        check(slowOscRun, 1'b0);
        wr(16'hff58, 8'h00, 1'b1, 3'h0);
        check(slowOscRun, 1'b1);
        doReset(clock_ctrl_pkg::SRC_EXTERNAL, 1'b0, 2'h0);
        wr(16'hff58, 8'h01, 1'b0, 3'h0);
        rd(16'hff58, v);
        check(v, 8'h00);
        check(slowOscRun, 1'b1);
        check(watchdogSlowLock, 1'b1);
        $display("test slow oscillator done");
        check({oscInPortMode, oscOutPortMode}, 2'h1);
        pulse(0, 0, n);
        check(extClkPass, 1'b0);
        pulse(1, 300, n);
        check(n, 0);
        check(extClkPass, 1'b1);
        $display("test external stop done");
        doReset(clock_ctrl_pkg::SRC_CRYSTAL, 1'b1, 2'h3);
        check({oscInPortMode, oscOutPortMode}, 2'h0);
        wr(16'hfff4, 8'h03, 1'b0, 3'h0);
        wr(16'hfff4, 8'h00, 1'b1, 3'h0);
        rd(16'hfff4, v);
        check(v, 8'h03);
        // Idle cycles before the start signal must not shorten the wait.
        for (int c = 0; c < 4; c++) begin
            wr(16'hfff4, c[7:0], 1'b0, 3'h0);
            pulse(0, 0, n);
            check(mainOscRun, 1'b0);
            pulse(1, 0, n);
            repeat (3) @(negedge core_clk);
            check(cpuClkRun, 1'b0);
            pulse(2, 300, n);
            check(n, W[c]);
        end
        $display("test crystal stop done");
        results();
    end
endmodule : system_clock_divider_control_tb
